// ### rtl/ipe_pkg.sv
// Purpose: Shared constants and types for the nine-bit input port with edge interrupts.
// Assumes: Avalon-MM slave with 32-bit data, byte addresses at four times the register index.
// Notes:   Register data sits in the low four bits; upper bits read as zero.
package ipe_pkg;

	localparam logic [9:0] IPE_IDX_G0_LEVEL  = 10'h2e3;
	localparam logic [9:0] IPE_IDX_G0_EDGE   = 10'h2e4;
	localparam logic [9:0] IPE_IDX_G0_ENABLE = 10'h2e5;
	localparam logic [9:0] IPE_IDX_SINGLE    = 10'h2e7;
	localparam logic [9:0] IPE_IDX_FLAGS_A   = 10'h2ea;
	localparam logic [9:0] IPE_IDX_FLAGS_B   = 10'h2f3;
	localparam logic [9:0] IPE_IDX_G1_LEVEL  = 10'h2f4;
	localparam logic [9:0] IPE_IDX_G1_ENABLE = 10'h2f5;

	localparam int IPE_SGL_LEVEL_BIT  = 0;
	localparam int IPE_SGL_EDGE_BIT   = 1;
	localparam int IPE_SGL_ENABLE_BIT = 2;
	localparam int IPE_SGL_TRIG_BIT   = 3;
	localparam int IPE_FLAG_G0_BIT    = 2;
	localparam int IPE_FLAG_SGL_BIT   = 3;
	localparam int IPE_FLAG_G1_BIT    = 1;

	localparam logic [3:0] IPE_RST_NIBBLE = 4'h0;
	localparam logic       IPE_RST_BIT    = 1'h0;

	localparam int IPE_CLK_HZ      = 50000000;
	localparam int IPE_NOISE_MS    = 1;
	localparam int IPE_NOISE_CYCLES = IPE_CLK_HZ / 1000 * IPE_NOISE_MS;

	typedef struct packed {
		logic [3:0] g0;
		logic       sgl;
		logic [3:0] g1;
	} ipe_pins_t;

	typedef struct packed {
		ipe_pins_t  s1;
		ipe_pins_t  s2;
		ipe_pins_t  s3;
		ipe_pins_t  lvl;
		logic [3:0] g0_edge;
		logic [3:0] g0_en;
		logic       sgl_edge;
		logic       sgl_en;
		logic [3:0] g1_en;
		logic       g0_match;
		logic       sgl_match;
		logic       g1_all_low;
		logic       flag_g0;
		logic       flag_sgl;
		logic       flag_g1;
		logic       rdv;
		logic [3:0] rdata;
		logic       trig;
		logic [19:0] noise_cnt;
	} ipe_state_t;

endpackage

// ### rtl/ipe_input_port.sv
// Purpose: Nine-bit input port with compare-mismatch and rising-edge interrupt factor flags.
// Assumes: Pins are asynchronous; software touches masks and flags only with interrupts disabled.
// Notes:   Reads answer one cycle after the request; writes answer at once.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module ipe_input_port
	import ipe_pkg::*;
#(
	parameter int NOISE_CYCLES = IPE_NOISE_CYCLES,
	parameter bit NOISE_REJECT = 1'b0
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic [3:0]  i_first_group_pins,
	input  wire logic        i_single_input_pin,
	input  wire logic [3:0]  i_second_group_pins,
	input  wire logic [11:0] i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic             o_event_input_a,
	output logic             o_event_input_b,
	output logic             o_serial_clock_trigger
);

	// The rejector counter is twenty bits wide, so longer windows cannot be served.
	if (NOISE_CYCLES < 1 || NOISE_CYCLES > 1000000) begin : g_bad_noise
		$error("NOISE_CYCLES out of range");
	end

	ipe_state_t st;
	ipe_state_t next_st;

	function automatic logic ipe_hit(input logic [11:0] addr, input logic [9:0] idx);
		ipe_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
	endfunction

	// Masked bits compare as matching so they can never block or cause a mismatch.
	function automatic logic ipe_match(input logic [3:0] lvl, input logic [3:0] cmp, input logic [3:0] en);
		ipe_match = ((lvl ^ cmp) & en) == 4'h0;
	endfunction

	logic       wr;
	logic       rd;
	logic       g0_m;
	logic       sg_m;
	logic       g1_low;
	logic       ev_g0;
	logic       ev_sg;
	logic       ev_g1;
	logic       stable;

	// A read is held in waitrequest for one cycle while its data is registered.
	assign o_avs_waitrequest      = i_avs_read & ~st.rdv;
	assign o_avs_readdata         = {28'h0000000, st.rdata};
	assign o_event_input_a        = st.lvl.g0[2];
	assign o_event_input_b        = st.lvl.g0[3];
	assign o_serial_clock_trigger = st.trig;

	always_comb begin
		next_st = st;
		wr = i_avs_write & i_avs_byteenable[0];
		rd = i_avs_read & ~st.rdv;

		// Three stages; a level change is accepted once the last two agree.
		next_st.s1 = {i_first_group_pins, i_single_input_pin, i_second_group_pins};
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		stable = (st.s2 == st.s3);
		if (st.s2 == st.s3)
			next_st.lvl = st.s3;

		// The comparison bit names the idle level: one means falling, zero rising.
		g0_m   = ipe_match(st.lvl.g0, st.g0_edge, st.g0_en);
		sg_m   = ipe_match({3'h0, st.lvl.sgl}, {3'h0, st.sgl_edge}, {3'h0, st.sgl_en});
		g1_low = (st.lvl.g1 & st.g1_en) == 4'h0;

		// An event needs a match before; mismatch to mismatch gives nothing.
		ev_g0 = st.g0_match & ~g0_m;
		ev_sg = st.sgl_match & ~sg_m;
		ev_g1 = st.g1_all_low & ~g1_low;

		// With the rejector, a condition must persist for the window before it counts.
		if (NOISE_REJECT) begin
			if (!stable)
				next_st.noise_cnt = 20'h00000;
			else if (st.noise_cnt < NOISE_CYCLES[19:0])
				next_st.noise_cnt = st.noise_cnt + 20'h00001;
			if (st.noise_cnt >= NOISE_CYCLES[19:0]) begin
				next_st.g0_match   = g0_m;
				next_st.sgl_match  = sg_m;
				next_st.g1_all_low = g1_low;
			end else begin
				ev_g0 = 1'b0;
				ev_sg = 1'b0;
				ev_g1 = 1'b0;
			end
		end else begin
			next_st.g0_match   = g0_m;
			next_st.sgl_match  = sg_m;
			next_st.g1_all_low = g1_low;
		end

		next_st.trig = 1'b0;
		if (wr) begin
			if (ipe_hit(i_avs_address, IPE_IDX_G0_EDGE))
				next_st.g0_edge = i_avs_writedata[3:0];
			if (ipe_hit(i_avs_address, IPE_IDX_G0_ENABLE))
				next_st.g0_en = i_avs_writedata[3:0];
			if (ipe_hit(i_avs_address, IPE_IDX_G1_ENABLE))
				next_st.g1_en = i_avs_writedata[3:0];
			if (ipe_hit(i_avs_address, IPE_IDX_SINGLE)) begin
				next_st.sgl_edge = i_avs_writedata[IPE_SGL_EDGE_BIT];
				next_st.sgl_en   = i_avs_writedata[IPE_SGL_ENABLE_BIT];
				next_st.trig     = i_avs_writedata[IPE_SGL_TRIG_BIT];
			end
		end

		next_st.rdv = rd;
		if (rd) begin
			next_st.rdata = 4'h0;
			if (ipe_hit(i_avs_address, IPE_IDX_G0_LEVEL))
				next_st.rdata = st.lvl.g0;
			if (ipe_hit(i_avs_address, IPE_IDX_G0_EDGE))
				next_st.rdata = st.g0_edge;
			if (ipe_hit(i_avs_address, IPE_IDX_G0_ENABLE))
				next_st.rdata = st.g0_en;
			if (ipe_hit(i_avs_address, IPE_IDX_SINGLE)) begin
				next_st.rdata[IPE_SGL_LEVEL_BIT]  = st.lvl.sgl;
				next_st.rdata[IPE_SGL_EDGE_BIT]   = st.sgl_edge;
				next_st.rdata[IPE_SGL_ENABLE_BIT] = st.sgl_en;
			end
			if (ipe_hit(i_avs_address, IPE_IDX_FLAGS_A)) begin
				next_st.rdata[IPE_FLAG_G0_BIT]  = st.flag_g0;
				next_st.rdata[IPE_FLAG_SGL_BIT] = st.flag_sgl;
				next_st.flag_g0  = 1'b0;
				next_st.flag_sgl = 1'b0;
			end
			if (ipe_hit(i_avs_address, IPE_IDX_FLAGS_B)) begin
				next_st.rdata[IPE_FLAG_G1_BIT] = st.flag_g1;
				next_st.flag_g1 = 1'b0;
			end
			if (ipe_hit(i_avs_address, IPE_IDX_G1_LEVEL))
				next_st.rdata = st.lvl.g1;
			if (ipe_hit(i_avs_address, IPE_IDX_G1_ENABLE))
				next_st.rdata = st.g1_en;
		end

		// Setting after the read-clear so an event in the clearing cycle survives.
		if (ev_g0)
			next_st.flag_g0 = 1'b1;
		if (ev_sg)
			next_st.flag_sgl = 1'b1;
		if (ev_g1)
			next_st.flag_g1 = 1'b1;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
			st.g0_edge    <= IPE_RST_NIBBLE;
			st.g0_en      <= IPE_RST_NIBBLE;
			st.g1_en      <= IPE_RST_NIBBLE;
			st.sgl_edge   <= IPE_RST_BIT;
			st.sgl_en     <= IPE_RST_BIT;
			st.g0_match   <= 1'b1;
			st.sgl_match  <= 1'b1;
			st.g1_all_low <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

endmodule

`default_nettype wire

// ### verif/ipe_asserts.sv
// Purpose: Port-level checks for the input port block.
// Assumes: Reads answer after one wait cycle, writes at once.
// Notes:   Bound to every instance of the block.
`timescale 1ns/100ps
`default_nettype none
module ipe_asserts (
	input wire logic        i_clk_sys,
	input wire logic        i_rst,
	input wire logic [3:0]  i_first_group_pins,
	input wire logic [11:0] i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0]  i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic        o_event_input_a,
	input wire logic        o_event_input_b,
	input wire logic        o_serial_clock_trigger
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	sequence s_rd_done;
		i_avs_read && !o_avs_waitrequest;
	endsequence
	sequence s_trig_wr;
		i_avs_write && i_avs_byteenable[0] && i_avs_address == 12'hb9c && i_avs_writedata[3];
	endsequence
	a_write_no_wait: assert property (i_avs_write |-> !o_avs_waitrequest) else $error("write stalled");
	a_read_one_wait: assert property (i_avs_read && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("read wait too long");
	a_upper_bits_zero: assert property (s_rd_done |-> o_avs_readdata[31:4] == 28'h0) else $error("upper bits set");
	a_unused_flags_zero: assert property (s_rd_done ##0 i_avs_address == 12'hbcc |-> o_avs_readdata[3:2] == 2'h0)
		else $error("unused flag bits set");
	a_trig_reads_zero: assert property (s_rd_done ##0 i_avs_address == 12'hb9c |-> !o_avs_readdata[3])
		else $error("trigger bit read back");
	a_trig_one_pulse: assert property (s_trig_wr |=> o_serial_clock_trigger ##1 !o_serial_clock_trigger)
		else $error("trigger pulse wrong");
	a_event_a_level: assert property ($stable(i_first_group_pins[2])[*8] |-> o_event_input_a == i_first_group_pins[2])
		else $error("event input a stale");
	a_event_b_level: assert property ($stable(i_first_group_pins[3])[*8] |-> o_event_input_b == i_first_group_pins[3])
		else $error("event input b stale");
endmodule
bind ipe_input_port ipe_asserts i_chk (.*);
`default_nettype wire

// ### verif/ipe_pin_model.sv
// Purpose: Switch bank that drives the nine input pins.
// Assumes: Pins are levels with no tie to the clock phase.
// Notes:   Moving on the falling edge exercises the synchroniser honestly.
`timescale 1ns/100ps
`default_nettype none
module ipe_pin_model (
	input  wire logic       i_clk_sys,
	input  wire logic [8:0] i_cmd,
	output var  logic [8:0] o_pins
);
	always @(negedge i_clk_sys) o_pins <= i_cmd;
endmodule
`default_nettype wire

// ### verif/ipe_input_port_tb.sv
// Purpose: Self-checking bench for the input port block.
// Assumes: Pins settle within eight cycles of a change.
// Notes:   Pin bits are ordered group0, single pin, group1.
`timescale 1ns/100ps
`default_nettype none
module ipe_input_port_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] adr = 12'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [3:0]  wd = 4'h0;
	logic [8:0]  cmd = 9'h0;
	logic [8:0]  pins;
	logic [31:0] rdat;
	logic [3:0]  rq;
	logic        wt;
	int          mismatches = 0;
	int          checks = 0;
	logic [17:0] rows [3] = '{{9'h1aa, 9'h1aa}, {9'h055, 9'h055}, 18'h0};
	ipe_pin_model i_ipe_pin_model (.i_clk_sys(clk), .i_cmd(cmd), .o_pins(pins));
	ipe_input_port i_ipe_input_port (.i_clk_sys(clk), .i_rst(rst), .i_first_group_pins(pins[8:5]),
		.i_single_input_pin(pins[4]), .i_second_group_pins(pins[3:0]), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata({28'h0, wd}), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wt), .o_event_input_a(), .o_event_input_b(),
		.o_serial_clock_trigger());
	initial forever #10 clk = ~clk;
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// The request stays up until an edge sees waitrequest low; read data is taken at that same edge.
	task automatic bus(input logic [11:0] a, input logic w, input logic [3:0] d);
		int n;
		@(posedge clk);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (wt === 1'b0)
				break;
		end
		if (n == 20) begin
			mismatches++;
			conclude();
		end
		rq = rdat[3:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [3:0] e);
		bus(a, 1'b0, 4'h0);
		cmp(rq, e);
	endtask
	task automatic pin(input logic [8:0] p);
		cmd <= p;
		repeat (8) @(posedge clk);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rc(12'hb90, 4'h0);
		rc(12'hb94, 4'h0);
		rc(12'hba8, 4'h0);
		rc(12'hbcc, 4'h0);
		foreach (rows[i]) begin
			pin(rows[i][17:9]);
			rc(12'hb8c, rows[i][8:5]);
			rc(12'hb9c, {3'h0, rows[i][4]});
			rc(12'hbd0, rows[i][3:0]);
		end
		bus(12'hb90, 1'b1, 4'h5);
		rc(12'hb90, 4'h5);
		bus(12'hb90, 1'b1, 4'h0);
		bus(12'hb94, 1'b1, 4'h3);
		rc(12'hb94, 4'h3);
		pin(9'h080);
		rc(12'hba8, 4'h0);
		pin(9'h0a0);
		rc(12'hba8, 4'h4);
		rc(12'hba8, 4'h0);
		pin(9'h0e0);
		rc(12'hba8, 4'h0);
		bus(12'hb90, 1'b1, 4'h7);
		pin(9'h0c0);
		rc(12'hba8, 4'h4);
		bus(12'hb9c, 1'b1, 4'h4);
		pin(9'h0d0);
		rc(12'hba8, 4'h8);
		bus(12'hb9c, 1'b1, 4'hc);
		rc(12'hb9c, 4'h5);
		bus(12'hbd4, 1'b1, 4'h7);
		pin(9'h0d8);
		rc(12'hbcc, 4'h0);
		pin(9'h0da);
		rc(12'hbcc, 4'h2);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rc(12'hb94, 4'h0);
		conclude();
	end
endmodule
`default_nettype wire
